// ---- verilog/terminal_port.sv ----
/*
 Top of the autobaud serial terminal port: AHB-Lite register slave,
 calibration from the first received character, echo, hex accumulation,
 guarded transmit and the programmable delay.
 Assumes one AHB master, single word transfers, and rxd synchronous to clock.
*/
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps

module terminal_port import serial_port_pkg::*; #(
   parameter int CNT_W = 16, // Bit time counter width
   parameter int DLY_W = 22  // Delay counter width
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic rxd,
   output logic txd
);

   // ==========================================================
   // Declarations
   typedef enum logic [4:0] {
      CAL_IDLE = 5'b00001, // Wait for the start edge (line low)
      CAL_LOW = 5'b00010,  // Start bit onward, wait first rise
      CAL_HIGH = 5'b00100, // Wait second fall
      CAL_TAIL = 5'b01000, // Let the rest of the frame pass
      CAL_RUN = 5'b10000   // Calibrated, normal operation
   } cal_state_t;

   cal_state_t cal_reg;
   control_t control_reg;        // Echo bit and halved timing parameter
   bus_phase_t phase_reg;        // Pending data phase
   logic [7:0] char_reg;         // char_holding_reg
   logic [15:0] hex_acc_reg;     // Hex accumulator
   logic hex_valid_flag;         // Last character was a hex digit
   logic hex_mode_reg;           // receive_hex_accumulate selected
   logic rx_done_reg;            // Sticky reception flag
   logic [7:0] prescale_reg;     // Counts 160 clock half units
   logic [11:0] units_reg;       // Half units since start edge
   logic [11:0] rise_reg;        // Half units at first rise
   logic [DLY_W-1:0] delay_cnt_reg; // Delay and guard countdown
   logic guard_reg;              // Guarded transmit waiting on counter
   logic echo_pend_reg;          // Echo still to be sent
   logic tx_pend_reg;            // Plain transmit still to be sent
   logic tx_start;               // Launch a frame this cycle
   logic tx_busy;
   logic rx_busy;
   logic rx_done;
   logic [DATA_BITS-1:0] rx_data;
   logic [CNT_W-1:0] bit_clocks; // Bit time in clocks
   logic [CNT_W:0] guard_clocks; // 1.5 bit times
   logic [DLY_W-1:0] delay_clocks; // Requested delay in clocks
   logic wr;                     // Data phase of a write
   logic [31:0] status_word;
   logic [4:0] hex_dec;          // Decoded received character
   logic [11:0] span;            // Two bit times in half units
   logic [11:0] tp_round;        // Rounded halved timing parameter
   logic is_cr;                  // First character looks like a return

   // ==========================================================
   // Helpers
   // Hex digit check: bit 4 valid, bits 3:0 digit value
   function automatic logic [4:0] hex_digit(input logic [6:0] c);
      logic [4:0] r;
      r = 5'h00;
      if (c >= 7'h30 && c <= 7'h39) begin
         r = {1'b1, 4'(c - 7'h30)};
      end else if (c >= 7'h41 && c <= 7'h46) begin
         r = {1'b1, 4'(c - 7'h37)};
      end
      return r;
   endfunction

   // Register select for a captured address
   function automatic logic hit(input bus_phase_t p, input logic [7:0] ofs);
      return p.valid && (p.addr == ofs);
   endfunction

   // Bit time is the even parameter times 160, i.e. halved times 320
   assign bit_clocks = CNT_W'(control_reg.tp_half * UNIT_CLOCKS);
   assign guard_clocks = {1'b0, bit_clocks} + (CNT_W + 1)'(bit_clocks >> 1);
   // Instruction count scaled by 16 clocks, m is the whole control byte
   assign delay_clocks = DLY_W'((DELAY_BASE + control_reg * (2 * hwdata[CMD_N_LSB +: 8] + DELAY_OFS))
      * INSTR_CLOCKS);
   assign wr = phase_reg.valid && phase_reg.write;
   assign hex_dec = hex_digit(rx_data);
   assign tx_start = !tx_busy && (echo_pend_reg || tx_pend_reg || (guard_reg && delay_cnt_reg == '0));

   // Carriage return has a one-bit start run, line feed a two-bit one
   assign is_cr = ({rise_reg, 1'b0} < 12'(3 * (units_reg - rise_reg)));
   assign span = is_cr ? units_reg : rise_reg;
   // Half-unit grid floors the span, so add half a step before rounding
   assign tp_round = (span + 12'h002) >> 2;

   assign status_word = {26'h0, guard_reg, rx_done_reg, (delay_cnt_reg != '0), tx_busy, rx_busy,
      (cal_reg != CAL_RUN)};

   // ==========================================================
   // Serial engines
   serial_rx #(.CNT_W(CNT_W)) u_rx (
      .clock(clock),
      .rst(rst),
      .enable(cal_reg == CAL_RUN),
      .rxd(rxd),
      .bit_clocks(bit_clocks),
      .busy(rx_busy),
      .done(rx_done),
      .data(rx_data)
   );

   serial_tx #(.CNT_W(CNT_W)) u_tx (
      .clock(clock),
      .rst(rst),
      .start(tx_start),
      .data(char_reg[DATA_BITS-1:0]),
      .bit_clocks(bit_clocks),
      .busy(tx_busy),
      .txd(txd)
   );

   // ==========================================================
   // AHB-Lite slave: zero wait states, always OKAY
   always_ff @(posedge clock) begin
      if (rst) begin
         phase_reg <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         // Only NONSEQ/SEQ with the bus ready open a data phase
         phase_reg.valid <= hsel && hready && htrans[1];
         phase_reg.write <= hwrite;
         phase_reg.addr <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Read data registered at the address phase; unmapped reads zero
   always_ff @(posedge clock) begin
      if (rst) begin
         hrdata <= 32'h0;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         unique case (haddr[7:0])
            OFS_CONTROL: hrdata <= {24'h0, control_reg};
            OFS_MODE: hrdata <= {31'h0, hex_mode_reg};
            OFS_CHAR: hrdata <= {24'h0, char_reg};
            OFS_HEX: hrdata <= {15'h0, hex_valid_flag, hex_acc_reg};
            OFS_STATUS: hrdata <= status_word;
            default: hrdata <= 32'h0;
         endcase
      end
   end

   // ==========================================================
   // Calibration sequencer, re-entered at reset or on command
   always_ff @(posedge clock) begin
      if (rst) begin
         cal_reg <= CAL_IDLE;
         prescale_reg <= 8'h0;
         units_reg <= 12'h0;
         rise_reg <= 12'h0;
      end else if (wr && hit(phase_reg, OFS_COMMAND) && hwdata[CMD_CAL]) begin
         cal_reg <= CAL_IDLE;
      end else begin
         // Free half-unit timebase, restarted at the start edge
         if (prescale_reg == 8'(HALF_UNIT_CLOCKS - 1)) begin
            prescale_reg <= 8'h0;
            if (units_reg != 12'hfff) begin
               units_reg <= units_reg + 12'h001;
            end
         end else begin
            prescale_reg <= prescale_reg + 8'h01;
         end
         unique case (cal_reg)
            CAL_IDLE: begin
               // Start edge opens the measurement
               if (!rxd) begin
                  cal_reg <= CAL_LOW;
                  prescale_reg <= 8'h0;
                  units_reg <= 12'h0;
               end
            end
            CAL_LOW: begin
               if (rxd) begin
                  rise_reg <= units_reg;
                  cal_reg <= CAL_HIGH;
               end
            end
            CAL_HIGH: begin
               // Second fall closes two successive bit times
               if (!rxd) begin
                  cal_reg <= CAL_TAIL;
               end
            end
            CAL_TAIL: begin
               // Wait past the parity bit, then for the stop level
               if (units_reg >= 12'(TAIL_HALF_BITS * control_reg.tp_half) && rxd) begin
                  cal_reg <= CAL_RUN;
               end
            end
            CAL_RUN: begin
               cal_reg <= CAL_RUN;
            end
         endcase
      end
   end

   // ==========================================================
   // Control constant: loaded by calibration or by software
   always_ff @(posedge clock) begin
      if (rst) begin
         control_reg <= CONTROL_RESET;
      end else if (cal_reg == CAL_HIGH && !rxd) begin
         // Clamp so the doubled value never reaches 255
         control_reg.tp_half <= (tp_round > 12'(TP_HALF_MAX)) ? 7'(TP_HALF_MAX) : tp_round[6:0];
         control_reg.echo_off <= !is_cr;
      end else if (wr && hit(phase_reg, OFS_CONTROL)) begin
         control_reg <= hwdata[7:0];
      end
   end

   // ==========================================================
   // Receive side effects: holding register and hex accumulator
   always_ff @(posedge clock) begin
      if (rst) begin
         char_reg <= CHAR_RESET;
         hex_acc_reg <= HEX_RESET;
         hex_valid_flag <= 1'b0;
         hex_mode_reg <= 1'b0;
      end else begin
         if (rx_done) begin
            // Hardware wins over a software write in the same cycle
            char_reg <= {1'b0, rx_data};
         end else if (wr && hit(phase_reg, OFS_CHAR)) begin
            char_reg <= hwdata[7:0];
         end
         if (rx_done && hex_mode_reg) begin
            if (hex_dec[4]) begin
               hex_acc_reg <= {hex_acc_reg[11:0], hex_dec[3:0]};
               hex_valid_flag <= 1'b1;
            end else begin
               hex_valid_flag <= 1'b0;
            end
         end
         if (wr && hit(phase_reg, OFS_MODE)) begin
            hex_mode_reg <= hwdata[MODE_HEX];
         end
      end
   end

   // Sticky reception flag; a new character beats the clear
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_done_reg <= 1'b0;
      end else if (rx_done) begin
         rx_done_reg <= 1'b1;
      end else if (wr && hit(phase_reg, OFS_STATUS) && hwdata[ST_RX_DONE]) begin
         rx_done_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Delay counter, shared by delay requests and the guard wait
   always_ff @(posedge clock) begin
      if (rst) begin
         delay_cnt_reg <= '0;
      end else if (wr && hit(phase_reg, OFS_COMMAND) && hwdata[CMD_TX_GUARD]) begin
         delay_cnt_reg <= DLY_W'(guard_clocks);
      end else if (wr && hit(phase_reg, OFS_COMMAND) && hwdata[CMD_DELAY]) begin
         delay_cnt_reg <= delay_clocks;
      end else if (delay_cnt_reg != '0) begin
         delay_cnt_reg <= delay_cnt_reg - 1'b1;
      end
   end

   // ==========================================================
   // Transmit requests; echo first, then plain, then guarded
   always_ff @(posedge clock) begin
      if (rst) begin
         echo_pend_reg <= 1'b0;
         tx_pend_reg <= 1'b0;
         guard_reg <= 1'b0;
      end else begin
         if (rx_done && cal_reg == CAL_RUN && !control_reg.echo_off) begin
            echo_pend_reg <= 1'b1;
         end else if (tx_start) begin
            echo_pend_reg <= 1'b0;
         end
         if (wr && hit(phase_reg, OFS_COMMAND) && hwdata[CMD_TX]) begin
            tx_pend_reg <= 1'b1;
         end else if (tx_start && !echo_pend_reg) begin
            tx_pend_reg <= 1'b0;
         end
         if (wr && hit(phase_reg, OFS_COMMAND) && hwdata[CMD_TX_GUARD]) begin
            guard_reg <= 1'b1;
         end else if (tx_start && !echo_pend_reg && !tx_pend_reg) begin
            guard_reg <= 1'b0;
         end
      end
   end

endmodule

// ---- verilog/serial_port_pkg.sv ----
/*
 Shared constants and types for the autobaud serial terminal port:
 register offsets, command and status bit positions, frame layout and timing.
 Assumes a single system clock; counts are in clock periods except where another unit is named.
*/
package serial_port_pkg;

   // ==========================================================
   // Register map (byte addresses, one aligned word each)
   localparam logic [7:0] OFS_CONTROL = 8'h00; // Control constant
   localparam logic [7:0] OFS_COMMAND = 8'h04; // Write-only command pulses
   localparam logic [7:0] OFS_MODE = 8'h08;    // Receive mode select
   localparam logic [7:0] OFS_CHAR = 8'h0c;    // Character holding register
   localparam logic [7:0] OFS_HEX = 8'h10;     // Accumulator and valid flag
   localparam logic [7:0] OFS_STATUS = 8'h14;  // Engine state

   // ==========================================================
   // Field positions
   localparam int CMD_CAL = 0;       // Re-enter calibration
   localparam int CMD_TX = 1;        // Plain transmit of holding register
   localparam int CMD_TX_GUARD = 2;  // Transmit after 1.5 bit guard
   localparam int CMD_DELAY = 3;     // Start a delay request
   localparam int CMD_N_LSB = 8;     // Delay parameter n, bits 15:8
   localparam int MODE_HEX = 0;      // Hex-accumulate receive mode
   localparam int HEX_VALID_BIT = 16; // Valid flag beside the accumulator
   localparam int ST_CAL = 0;        // Calibrating
   localparam int ST_RX_BUSY = 1;
   localparam int ST_TX_BUSY = 2;
   localparam int ST_DELAY_BUSY = 3;
   localparam int ST_RX_DONE = 4;    // Sticky, write one to clear
   localparam int ST_GUARD = 5;      // Guarded transmit waiting

   // ==========================================================
   // Reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] CHAR_RESET = 8'h00;
   localparam logic [15:0] HEX_RESET = 16'h0000;

   // ==========================================================
   // Frame and timing
   localparam int DATA_BITS = 7;       // Data bits per frame
   localparam int FRAME_BITS = 11;     // Start, 7 data, parity, 2 stop
   localparam int INSTR_CLOCKS = 16;   // Clocks per instruction time
   localparam int SAMPLE_INSTR = 20;   // Instruction times per sample
   localparam int UNIT_CLOCKS = SAMPLE_INSTR * INSTR_CLOCKS; // 320
   localparam int HALF_UNIT_CLOCKS = UNIT_CLOCKS / 2;        // 160
   localparam int TP_HALF_MAX = 127;   // Keeps the parameter at 254 or less
   localparam int TAIL_HALF_BITS = 19; // 9.5 bit times before idle wait
   localparam int DELAY_BASE = 20;     // Fixed delay part, instruction times
   localparam int DELAY_OFS = 6;       // Added to 2n
   localparam logic [6:0] CHAR_CR = 7'h0d;
   localparam logic [6:0] CHAR_LF = 7'h0a;

   // Control constant: even timing parameter plus the echo bit
   typedef struct packed {
      logic [6:0] tp_half; // Timing parameter divided by two
      logic echo_off;      // Zero echoes, one suppresses
   } control_t;

   // Captured AHB address phase
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } bus_phase_t;

endpackage

// ---- verilog/serial_rx.sv ----
/*
 Asynchronous character receiver: start bit, seven data bits LSB first,
 a parity bit that is thrown away, then one stop bit is sampled.
 Assumes rxd is already synchronous and bit_clocks is nonzero.
*/
`timescale 1ns/1ps
module serial_rx import serial_port_pkg::*; #(
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic enable,              // Low keeps an idle receiver from starting a frame
   input wire logic rxd,
   input wire logic [CNT_W-1:0] bit_clocks,
   output logic busy,
   output logic done,                    // One-cycle pulse per character
   output logic [DATA_BITS-1:0] data
);

   // ==========================================================
   // State and counters
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_START = 3'b010,
      RX_BITS = 3'b100
   } rx_state_t;

   rx_state_t state_reg;
   logic [CNT_W-1:0] cnt_reg;   // Clocks to next sample
   logic [3:0] bitn_reg;        // Sample index after the start bit
   logic [DATA_BITS-1:0] sr_reg; // Data shifted in LSB first

   assign busy = (state_reg != RX_IDLE);
   assign data = sr_reg;

   // ==========================================================
   // Frame sequencer; returns to idle at mid stop bit so that
   // a following start edge is caught without loss
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= RX_IDLE;
         cnt_reg <= '0;
         bitn_reg <= 4'h0;
         sr_reg <= '0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state_reg)
            RX_IDLE: begin
               // Low line while idle is taken as a start edge
               if (enable && !rxd) begin
                  state_reg <= RX_START;
                  cnt_reg <= bit_clocks >> 1;
               end
            end
            RX_START: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 1'b1;
               end else if (!rxd) begin
                  state_reg <= RX_BITS;
                  cnt_reg <= bit_clocks - 1'b1;
                  bitn_reg <= 4'h0;
               end else begin
                  // Glitch, not a start bit
                  state_reg <= RX_IDLE;
               end
            end
            RX_BITS: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 1'b1;
               end else begin
                  cnt_reg <= bit_clocks - 1'b1;
                  bitn_reg <= bitn_reg + 4'h1;
                  if (bitn_reg < 4'(DATA_BITS)) begin
                     sr_reg <= {rxd, sr_reg[DATA_BITS-1:1]};
                  end else if (bitn_reg == 4'(DATA_BITS + 1)) begin
                     // Parity sample skipped, stop sample ends frame
                     done <= 1'b1;
                     state_reg <= RX_IDLE;
                  end
               end
            end
         endcase
      end
   end

endmodule

// ---- verilog/serial_tx.sv ----
/*
 Asynchronous character transmitter: start bit, seven data bits LSB first,
 a parity bit forced to one, and two stop bits.
 Assumes start is only raised while busy is low.
*/
`timescale 1ns/1ps
module serial_tx import serial_port_pkg::*; #(
   parameter int CNT_W = 16
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,               // One-cycle request
   input wire logic [DATA_BITS-1:0] data,
   input wire logic [CNT_W-1:0] bit_clocks,
   output logic busy,
   output logic txd                      // Registered line, rests high
);

   // ==========================================================
   // Shift state
   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } tx_state_t;

   tx_state_t state_reg;
   logic [CNT_W-1:0] cnt_reg;       // Clocks left in current bit
   logic [3:0] left_reg;            // Bits still to send
   logic [FRAME_BITS-1:0] sr_reg;   // Frame, LSB goes out first

   assign busy = (state_reg != TX_IDLE);

   // ==========================================================
   // Serialiser
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= TX_IDLE;
         cnt_reg <= '0;
         left_reg <= 4'h0;
         sr_reg <= '1;
         txd <= 1'b1;
      end else begin
         unique case (state_reg)
            TX_IDLE: begin
               txd <= 1'b1;
               if (start) begin
                  // Stop, stop, parity one, data, start zero
                  sr_reg <= {2'b11, 1'b1, data, 1'b0};
                  left_reg <= 4'(FRAME_BITS);
                  cnt_reg <= '0;
                  state_reg <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (cnt_reg != '0) begin
                  cnt_reg <= cnt_reg - 1'b1;
               end else if (left_reg == 4'h0) begin
                  txd <= 1'b1;
                  state_reg <= TX_IDLE;
               end else begin
                  txd <= sr_reg[0];
                  sr_reg <= {1'b1, sr_reg[FRAME_BITS-1:1]};
                  left_reg <= left_reg - 4'h1;
                  cnt_reg <= bit_clocks - 1'b1;
               end
            end
         endcase
      end
   end

endmodule

// ---- dv/tp_monitor.sv ----
/* Port checker for terminal_port.
 Assumes each serial bit lasts a whole multiple of 320 clocks. */
`timescale 1ns/1ps
module tp_monitor import serial_port_pkg::*; (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic txd
);
   // ==========
   // Line run lengths and read address phases
   int unsigned lo_cnt;
   int unsigned hi_cnt;
   logic rd;
   assign rd = hsel && hready && htrans[1] && !hwrite;
   // Run counters restart on every level change
   always_ff @(posedge clock) begin
      lo_cnt <= (rst || txd) ? 0 : lo_cnt + 1;
      hi_cnt <= (rst || !txd) ? 0 : hi_cnt + 1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   property p_rdy; hreadyout; endproperty
   a_rdy: assert property (p_rdy) else $error("wait state");
   property p_okay; !hresp; endproperty
   a_okay: assert property (p_okay) else $error("error response");
   property p_ctl; rd && haddr[7:0] == OFS_CONTROL |=> hrdata[31:8] == 0; endproperty
   a_ctl: assert property (p_ctl) else $error("control read");
   property p_chr; rd && haddr[7:0] == OFS_CHAR |=> hrdata[31:7] == 0; endproperty
   a_chr: assert property (p_chr) else $error("char read");
   property p_hex; rd && haddr[7:0] == OFS_HEX |=> hrdata[31:17] == 0; endproperty
   a_hex: assert property (p_hex) else $error("hex read");
   property p_cmd; rd && haddr[7:0] == OFS_COMMAND |=> hrdata == 0; endproperty
   a_cmd: assert property (p_cmd) else $error("command read");
   property p_low; $rose(txd) |-> lo_cnt != 0 && lo_cnt % 320 == 0; endproperty
   a_low: assert property (p_low) else $error("low run");
   property p_high; $fell(txd) |-> hi_cnt >= 320; endproperty
   a_high: assert property (p_high) else $error("high run");
   property p_start; $fell(txd) |=> !txd [*8]; endproperty
   a_start: assert property (p_start) else $error("start bit");
   c_tx: cover property ($fell(txd));
   c_hex: cover property (rd && haddr[7:0] == OFS_HEX);
   c_ctl: cover property (hsel && htrans[1] && hwrite && haddr[7:0] == OFS_CONTROL);
endmodule
bind terminal_port tp_monitor u_mon (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .txd(txd));

// ---- dv/tp_term.sv ----
/* Terminal model: frames characters onto rxd, decodes frames seen on txd.
 Assumes one bit is 320 clocks of 100 ns. */
`timescale 1ns/1ps
module tp_term #(
   parameter int BIT_NS = 32000 // Whole multiple of 320 clocks, no rounding loss
) (
   output logic rxd,
   input wire logic txd
);
   // ==========
   // Sender and decoder
   logic [9:0] got[$]; // Frames as stop, stop, parity, data
   logic [9:0] sh;
   initial rxd = 1; // Mark while idle
   // Changes land 10 ns after the calling time, never on an edge
   task automatic send(input logic [6:0] c, input logic par, input int stops);
      #10 rxd = 0; // Start bit
      for (int i = 0; i < 8; i++) begin
         #BIT_NS rxd = i < 7 ? c[i] : par; // Data low first then parity
      end
      #BIT_NS rxd = 1;
      #(BIT_NS * stops); // One or two stops
   endtask
   // Samples each bit after the start bit of an outgoing frame at its middle
   always begin
      @(negedge txd);
      #(BIT_NS / 2);
      for (int i = 0; i < 10; i++) #BIT_NS sh[i] = txd;
      got.push_back(sh);
   end
endmodule

// ---- dv/autobaud_serial_terminal_port_tb.sv ----
/* Bench for terminal_port against a terminal model.
 Assumes calibration from a carriage return sent at 320 clocks a bit. */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
$display("[ERR] %0t %h %h", $time, (a), (b)); end end
module autobaud_serial_terminal_port_tb import serial_port_pkg::*; ;
   // ==========
   // Bus, line and model state
   logic clock = 0, rst = 1, hsel = 0, hwrite = 0, hrdy, rxd, txd;
   logic [1:0] htrans = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r, seed = 48;
   logic [9:0] f;
   int err_count = 0, samples_checked = 0, acc = 0, vld = 0, ch, d;
   string hx = "0123456789ABCDEF";
   terminal_port u_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy),
      .hrdata(hrdata), .hresp(), .rxd(rxd), .txd(txd));
   tp_term u_term (.rxd(rxd), .txd(txd));
   initial forever #50 clock = ~clock;
   // Hang guard, past the roughly 81k cycles the tests need
   initial begin
      #9_500_000;
      err_count++;
      give_verdict();
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // One single AHB transfer; read data lands in r
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      hsel <= 1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clock); while (!hrdy);
      hsel <= 0;
      htrans <= 0;
      hwdata <= v;
      do @(posedge clock); while (!hrdy);
      r = hrdata;
   endtask
   // Waits for one decoded frame and checks it
   task automatic frame(input logic [6:0] c);
      repeat (6000) if (u_term.got.size() == 0) @(posedge clock);
      f = u_term.got.pop_front();
      `CHK(f, {3'b111, c}) // Framing
   endtask
   task give_verdict();
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clock);
      rst <= 0;
      bus(0, OFS_STATUS, 0);
      `CHK(r[ST_CAL], 1'b1) // Calibrating
      u_term.send(CHAR_CR, 1, 2); // Echo wanted
      repeat (4000) @(posedge clock);
      bus(0, OFS_CONTROL, 0);
      `CHK(r[7:0], 8'h02) // Timing and echo
      u_term.got.delete();
      bus(1, OFS_MODE, 1);
      // Random hex and other characters with echo on
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         ch = r[7] ? hx[r[3:0]] : r[14:8];
         vld = ch inside {[48:57], [65:70]};
         if (vld) acc = (acc << 4 | (ch > 57 ? ch - 55 : ch - 48)) & 'hffff;
         u_term.send(ch[6:0], r[16], 1 + r[17]); // Any parity
         frame(ch[6:0]); // Echo
         bus(0, OFS_CHAR, 0);
         `CHK(r[7:0], ch[7:0]) // Holding
         bus(0, OFS_HEX, 0);
         `CHK(r[16:0], {vld[0], acc[15:0]}) // Accumulator
      end
      // Recalibrate from a line feed; the command word reads back as zero
      bus(1, OFS_COMMAND, 1 << CMD_CAL);
      bus(0, OFS_COMMAND, 0);
      `CHK(r, 32'h0) // Write-only command
      u_term.send(CHAR_LF, 1, 2);
      repeat (10) @(posedge clock);
      bus(0, OFS_CONTROL, 0);
      `CHK(r[7:0], 8'h03) // Same timing, echo off
      // Echo off, two characters back to back
      bus(1, OFS_CONTROL, 3);
      u_term.send(7'h41, 0, 1);
      u_term.send(7'h2a, 1, 1);
      repeat (4000) @(posedge clock);
      bus(0, OFS_CHAR, 0);
      `CHK({r[7:0], u_term.got.size()}, {8'h2a, 32'h0}) // Last kept, none echoed
      bus(0, OFS_STATUS, 0);
      `CHK(r[ST_RX_DONE], 1'b1) // Reception seen
      bus(1, OFS_STATUS, 1 << ST_RX_DONE);
      bus(0, OFS_STATUS, 0);
      `CHK(r[ST_RX_DONE], 1'b0) // Cleared by software
      // Plain then guarded transmit
      for (int k = 1; k < 3; k++) begin
         ch = rnd() % 128;
         bus(1, OFS_CHAR, ch);
         bus(1, OFS_COMMAND, 1 << k);
         frame(ch[6:0]); // Sent from holding
      end
      d = rnd() % 16;
      bus(1, OFS_COMMAND, d << 8 | 8);
      d = int'($time / 100) + (20 + 3 * (2 * d + 6)) * 16;
      r = 8;
      for (int k = 0; k < 3000 && r[ST_DELAY_BUSY]; k++) bus(0, OFS_STATUS, 0);
      d = int'($time / 100) - d;
      `CHK(d inside {[-8:8]}, 1'b1) // Delay length
      give_verdict();
   end
endmodule
